// ===== dv/sbst_ctl_model.sv
// Behavioural scan controller that drives the test clock, mode select and serial input.
// Assumes the test clock stands still low between frames and that tdo_in settles within half a period.
module sbst_ctl_model (
    output sbst_pkg::sbst_pins_s scan_out,
    input  wire logic            tdo_in
);
    timeunit 1ns;
    timeprecision 1ns;
    import sbst_pkg::*;

    // Start with the test clock parked low.
    initial scan_out = '0;

    // One 800 ns test clock period: set pins, sample serial output at the end of the low phase.
    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        scan_out.tms = tms;
        scan_out.tdi = tdi;
        #400;
        tdo = tdo_in;
        scan_out.tck = 1'h1;
        #400;
        scan_out.tck = 1'h0;
    endtask

    // Five high mode-select periods reach test-logic-reset, then park in idle.
    task automatic reset_tap();
        logic t;
        repeat (5) tick(1'h1, 1'h0, t);
        tick(1'h0, 1'h0, t);
    endtask

    // Full capture, shift and update walk from idle back to idle; only documented codes are ever shifted.
    task automatic scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
        logic t;
        dout = '0;
        tick(1'h1, 1'h0, t);
        if (ir) tick(1'h1, 1'h0, t);
        tick(1'h0, 1'h0, t);
        tick(1'h0, 1'h0, t);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], t);
            dout[i] = t;
        end
        tick(1'h1, 1'h0, t);
        tick(1'h0, 1'h0, t);
    endtask
endmodule

// ===== dv/tb.sv
// Self-checking bench of the scan port: controller model on the pins, snapshot words into the buffer.
// Assumes the design settles its registered outputs within four system clocks after a test clock edge.
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
    $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sbst_pkg::*;

    localparam logic [10:0] MFR = 11'h2AB; // Arbitrary value.
    localparam logic [16:0] CFG = {1'h0, 1'h1, DENS_36MB, 1'h0, WIDTH_X18, 2'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1,
                                   1'h0, 1'h0};
    localparam logic [31:0] ID_WORD = {ID_REVISION, CFG, MFR, 1'h1};

    logic                  clk_in;
    logic                  rstn_in;
    sbst_pins_s            scan;
    logic                  ball_valid_in;
    logic [BALL_CELLS-1:0] ball_data_in;
    logic                  ball_ready, tdo, tdo_oe, q_en, extest;
    logic [BALL_CELLS-1:0] preload;
    logic                  tdo_pin;
    logic [127:0]          din, dout, prev;
    logic [2:0]            mode;
    int                    miscompares = 0;
    int                    n_tests = 0;

    sbst_tap #(.DENSITY(DENS_36MB), .WIDTH_SEL(WIDTH_X18), .F_RL25(1'h1), .F_ODT(1'h1),
               .MFR_CODE(MFR)) sbst_tap_inst (
        .clk_in(clk_in), .rstn_in(rstn_in), .scan_in(scan), .ball_valid_in(ball_valid_in),
        .ball_data_in(ball_data_in), .ball_ready_out(ball_ready), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
        .q_drive_en_out(q_en), .extest_out(extest), .preload_out(preload));

    // Undriven serial output shows the inverse of its last level so a stale bit never passes.
    assign tdo_pin = tdo_oe ? tdo : ~tdo;

    sbst_ctl_model sbst_ctl_model_inst (.scan_out(scan), .tdo_in(tdo_pin));

    // System clock of 100 ns.
    initial begin
        clk_in = 1'h0;
        forever #50 clk_in = ~clk_in;
    end

    // Prints the verdict and ends the run.
    task automatic finish_test();
        if (miscompares == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Snapshot word k, distinct from the patterns shifted in.
    function automatic logic [107:0] word(input int k);
        return {27{4'(k) ^ 4'hA}};
    endfunction

    // Output driver enable expected for an instruction and a latched internal cell.
    function automatic logic qexp(input logic [2:0] m, input logic c);
        return (m == INS_EXTEST) ? c : (m != INS_SAMPLE_Z);
    endfunction

    // Loads an instruction, checking the captured instruction pattern.
    task automatic load_ir(input logic [2:0] code);
        sbst_ctl_model_inst.scan(1'h1, IR_LEN, {125'h0, code}, dout);
        `CHK(dout[2:0], IR_CAPTURE)
    endtask

    // Reads the identification word straight after a controller reset.
    task automatic check_id();
        sbst_ctl_model_inst.scan(1'h0, ID_LEN, '0, dout);
        `CHK(dout[31:0], ID_WORD)
        `CHK(tdo_oe, 1'h0)
    endtask

    // Offers one snapshot word and checks whether the buffer could take it.
    task automatic push(input int k, input logic exp_rdy);
        ball_valid_in = 1'h1;
        ball_data_in = word(k);
        `CHK(ball_ready, exp_rdy)
        @(posedge clk_in);
        #1;
    endtask

    // Run time is about 2200 test clock periods; the watchdog allows more than twice that.
    initial begin
        #4_000_000;
        miscompares++;
        finish_test();
    end

    // Main sequence.
    initial begin
        rstn_in = 1'h0;
        ball_valid_in = 1'h0;
        ball_data_in = '0;
        repeat (8) @(posedge clk_in);
        #1;
        rstn_in = 1'h1;
        #500;
        sbst_ctl_model_inst.reset_tap();
        check_id();
        // Fill the buffer until it refuses a seventeenth word.
        for (int k = 0; k < 17; k++) push(k, k < 16);
        ball_valid_in = 1'h0;
        // Bypass: one zero then the delayed input.
        load_ir(INS_BYPASS);
        sbst_ctl_model_inst.scan(1'h0, 4, 128'hD, dout);
        `CHK(dout[3:0], 4'hA)
        // Boundary instructions drain the buffer; the last capture finds it empty.
        prev = '0;
        for (int k = 0; k < 17; k++) begin
            mode = (k == 1) ? INS_EXTEST : (k == 2) ? INS_SAMPLE_Z : INS_SAMPLE;
            load_ir(mode);
            `CHK(extest, mode == INS_EXTEST)
            `CHK(q_en, qexp(mode, prev[108]))
            din = {19'h0, k != 1, {27{4'(~k)}}};
            sbst_ctl_model_inst.scan(1'h0, BSR_LEN, din, dout);
            `CHK(dout[107:0], (k < 16) ? word(k) : prev[107:0])
            `CHK(dout[108], prev[108])
            `CHK(preload, din[107:0])
            `CHK(q_en, qexp(mode, din[108]))
            `CHK(ball_ready, 1'h1)
            prev = din;
        end
        // Controller reset restores the identification instruction and clears the latches.
        sbst_ctl_model_inst.reset_tap();
        `CHK(preload, 108'h0)
        `CHK(extest, 1'h0)
        `CHK(q_en, 1'h1)
        check_id();
        finish_test();
    end
endmodule

// ===== logic/sbst_fifo.sv
// Synchronous FIFO holding ball snapshots on their way to the boundary chain.
// Assumes DEPTH is a power of two so the pointers wrap naturally.
module sbst_fifo #(
    parameter int WIDTH = 108,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_in,
    input  wire logic             rstn_in,
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    output logic                  out_valid_out,
    output logic [WIDTH-1:0]      out_data_out,
    input  wire logic             out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    logic [CW-1:0]    next_count;
    logic             push;
    logic             pop;

    // Handshakes on both sides and the resulting fill level.
    assign push = in_valid_in && in_ready_out;
    assign pop  = out_valid_out && out_ready_in;
    assign out_valid_out = (count != CW'(0));
    assign out_data_out  = mem[rd_ptr];
    always_comb begin
        next_count = count + CW'(push) - CW'(pop);
    end

    // Fill level and a registered ready that drops when the FIFO is full.
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            count        <= '0;
            in_ready_out <= 1'b1;
        end else begin
            count        <= next_count;
            in_ready_out <= (next_count != CW'(DEPTH));
        end
    end

    // Pointers advance on each accepted word.
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + AW'(1);
            if (pop)  rd_ptr <= rd_ptr + AW'(1);
        end
    end

    // Storage needs no reset; only written words are ever read.
    always_ff @(posedge clk_in) begin
        if (push) mem[wr_ptr] <= in_data_in;
    end
endmodule

// ===== logic/sbst_pkg.sv
// Shared constants and types of the SRAM boundary scan test access port.
// Assumes one clock domain, clk_in, that samples the scan pins as plain inputs.
package sbst_pkg;

    // Register lengths of the scan paths.
    localparam int IR_LEN     = 3;
    localparam int ID_LEN     = 32;
    localparam int BSR_LEN    = 109;
    localparam int BALL_CELLS = 108;
    localparam int OE_CELL    = 108;

    // Instruction codes.
    localparam logic [2:0] INS_EXTEST   = 3'h0;
    localparam logic [2:0] INS_IDCODE   = 3'h1;
    localparam logic [2:0] INS_SAMPLE_Z = 3'h2;
    localparam logic [2:0] INS_RESV_A   = 3'h3;
    localparam logic [2:0] INS_SAMPLE   = 3'h4;
    localparam logic [2:0] INS_RESV_B   = 3'h5;
    localparam logic [2:0] INS_RESV_C   = 3'h6;
    localparam logic [2:0] INS_BYPASS   = 3'h7;

    // Value loaded into the instruction shifter in capture, and reset values.
    localparam logic [2:0] IR_CAPTURE   = 3'h1;
    localparam logic [2:0] IR_RESET     = INS_IDCODE;
    localparam logic       OE_CELL_RST  = 1'h0;

    // Identification word field positions.
    localparam int ID_REV_LSB  = 29;
    localparam int ID_CFG_LSB  = 12;
    localparam int ID_MFR_LSB  = 1;
    localparam int ID_START    = 0;
    localparam logic [2:0] ID_REVISION = 3'h0;

    // Part configuration subfield encodings.
    localparam logic [2:0] DENS_18MB = 3'h1;
    localparam logic [2:0] DENS_36MB = 3'h2;
    localparam logic [2:0] DENS_72MB = 3'h3;
    localparam logic [1:0] WIDTH_X36 = 2'h3;
    localparam logic [1:0] WIDTH_X18 = 2'h2;

    // Test access controller states.
    typedef enum logic [3:0] {
        ST_RESET   = 4'h0, ST_IDLE    = 4'h1, ST_SEL_DR  = 4'h2, ST_CAP_DR  = 4'h3,
        ST_SH_DR   = 4'h4, ST_EX1_DR  = 4'h5, ST_PA_DR   = 4'h6, ST_EX2_DR  = 4'h7,
        ST_UPD_DR  = 4'h8, ST_SEL_IR  = 4'h9, ST_CAP_IR  = 4'hA, ST_SH_IR   = 4'hB,
        ST_EX1_IR  = 4'hC, ST_PA_IR   = 4'hD, ST_EX2_IR  = 4'hE, ST_UPD_IR  = 4'hF
    } sbst_state_e;

    // Scan pins driven by the test controller.
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } sbst_pins_s;

endpackage

// ===== logic/sbst_tap.sv
// Boundary scan test access port of a synchronous burst SRAM.
// Assumes the scan pins are asynchronous to clk_in and that clk_in is many times faster than the test clock.
module sbst_tap #(
    parameter logic [2:0]  DENSITY    = 3'h3,
    parameter logic [1:0]  WIDTH_SEL  = 2'h3,
    parameter logic        F_ENH      = 1'h1,
    parameter logic        F_QUADP    = 1'h0,
    parameter logic        F_RL25     = 1'h0,
    parameter logic        F_BURST4   = 1'h1,
    parameter logic        F_SIO      = 1'h0,
    parameter logic        F_ODT      = 1'h0,
    parameter logic [10:0] MFR_CODE   = 11'h155, // Arbitrary value.
    parameter int          FIFO_DEPTH = 16
) (
    input  wire logic                            clk_in,
    input  wire logic                            rstn_in,
    input  wire sbst_pkg::sbst_pins_s            scan_in,
    input  wire logic                            ball_valid_in,
    input  wire logic [sbst_pkg::BALL_CELLS-1:0] ball_data_in,
    output logic                                 ball_ready_out,
    output logic                                 tdo_out,
    output logic                                 tdo_oe_out,
    output logic                                 q_drive_en_out,
    output logic                                 extest_out,
    output logic [sbst_pkg::BALL_CELLS-1:0]      preload_out
);
    import sbst_pkg::*;

    sbst_pins_s            pins_s1;
    sbst_pins_s            pins_s2;
    logic                  tck_d;
    logic                  rise;
    logic                  fall;
    sbst_state_e           state;
    sbst_state_e           next_state;
    logic [IR_LEN-1:0]     ir;
    logic [IR_LEN-1:0]     ir_sh;
    logic [BSR_LEN-1:0]    bsr;
    logic [ID_LEN-1:0]     id_sh;
    logic [ID_LEN-1:0]     id_word;
    logic                  byp;
    logic                  oe_cell;
    logic                  sel_bsr;
    logic                  sel_id;
    logic                  cap_bsr;
    logic                  snap_valid;
    logic [BALL_CELLS-1:0] snap_data;

    // Two-stage synchronisers for the scan pins, then edge detection of the test clock.
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            pins_s1 <= '0;
            pins_s2 <= '0;
            tck_d   <= 1'b0;
        end else begin
            pins_s1 <= scan_in;
            pins_s2 <= pins_s1;
            tck_d   <= pins_s2.tck;
        end
    end
    assign rise = pins_s2.tck && !tck_d;
    assign fall = !pins_s2.tck && tck_d;

    // Identification word built from fixed fields.
    assign id_word = {ID_REVISION,
                      1'b0, F_ODT, DENSITY, 1'b0, WIDTH_SEL, 2'h1,
                      F_ENH, F_QUADP, F_RL25, F_BURST4, F_ODT, F_SIO, 1'b0,
                      MFR_CODE, 1'b1};

    // Data path selection; reserved codes fall back to bypass.
    assign sel_bsr = (ir == INS_EXTEST) || (ir == INS_SAMPLE_Z) || (ir == INS_SAMPLE);
    assign sel_id  = (ir == INS_IDCODE);
    assign cap_bsr = rise && (state == ST_CAP_DR) && sel_bsr;

    // Ball snapshots queue here until a boundary capture takes one.
    sbst_fifo #(
        .WIDTH (BALL_CELLS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (clk_in),
        .rstn_in       (rstn_in),
        .in_valid_in   (ball_valid_in),
        .in_data_in    (ball_data_in),
        .in_ready_out  (ball_ready_out),
        .out_valid_out (snap_valid),
        .out_data_out  (snap_data),
        .out_ready_in  (cap_bsr)
    );

    // Next state of the controller from the mode select input.
    always_comb begin
        next_state = state;
        unique case (state)
            ST_RESET:  next_state = pins_s2.tms ? ST_RESET  : ST_IDLE;
            ST_IDLE:   next_state = pins_s2.tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_state = pins_s2.tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_state = pins_s2.tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  next_state = pins_s2.tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: next_state = pins_s2.tms ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR:  next_state = pins_s2.tms ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: next_state = pins_s2.tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: next_state = pins_s2.tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_state = pins_s2.tms ? ST_RESET  : ST_CAP_IR;
            ST_CAP_IR: next_state = pins_s2.tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  next_state = pins_s2.tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: next_state = pins_s2.tms ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR:  next_state = pins_s2.tms ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: next_state = pins_s2.tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: next_state = pins_s2.tms ? ST_SEL_DR : ST_IDLE;
        endcase
    end

    // Controller state advances on each rising test clock edge.
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            state <= ST_RESET;
        end else if (rise) begin
            state <= next_state;
        end
    end

    // Instruction shifter captures and shifts on the rising edge, and updates the instruction on the falling edge.
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            ir_sh <= IR_CAPTURE;
            ir    <= IR_RESET;
        end else begin
            if (rise && state == ST_CAP_IR) ir_sh <= IR_CAPTURE;
            if (rise && state == ST_SH_IR)  ir_sh <= {pins_s2.tdi, ir_sh[IR_LEN-1:1]};
            if (state == ST_RESET) begin
                ir <= IR_RESET;
            end else if (fall && state == ST_UPD_IR) begin
                ir <= ir_sh;
            end
        end
    end

    // Boundary chain: capture takes a queued snapshot, shifting enters at the MSB.
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            bsr <= '0;
        end else if (cap_bsr && snap_valid) begin
            bsr[BALL_CELLS-1:0] <= snap_data;
        end else if (rise && state == ST_SH_DR && sel_bsr) begin
            bsr <= {pins_s2.tdi, bsr[BSR_LEN-1:1]};
        end
    end

    // Identification shifter and bypass bit.
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            id_sh <= '0;
            byp   <= 1'b0;
        end else if (rise && state == ST_CAP_DR) begin
            if (sel_id) id_sh <= id_word;
            byp <= 1'b0;
        end else if (rise && state == ST_SH_DR) begin
            if (sel_id) id_sh <= {pins_s2.tdi, id_sh[ID_LEN-1:1]};
            byp <= pins_s2.tdi;
        end
    end

    // Preload latches update on the falling edge in Update-DR; the internal cell resets low.
    always_ff @(posedge clk_in) begin
        if (!rstn_in || state == ST_RESET) begin
            preload_out <= '0;
            oe_cell     <= OE_CELL_RST;
        end else if (fall && state == ST_UPD_DR && sel_bsr) begin
            preload_out <= bsr[BALL_CELLS-1:0];
            oe_cell     <= bsr[OE_CELL];
        end
    end

    // Output driver control follows the active instruction.
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            extest_out     <= 1'b0;
            q_drive_en_out <= 1'b1;
        end else begin
            extest_out <= (ir == INS_EXTEST);
            if (ir == INS_EXTEST) begin
                q_drive_en_out <= oe_cell;
            end else begin
                q_drive_en_out <= (ir != INS_SAMPLE_Z);
            end
        end
    end

    // Serial output launches on the falling edge and is driven only in shift states.
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            tdo_out    <= 1'b0;
            tdo_oe_out <= 1'b0;
        end else if (fall) begin
            tdo_oe_out <= (state == ST_SH_DR) || (state == ST_SH_IR);
            if (state == ST_SH_IR)    tdo_out <= ir_sh[0];
            else if (sel_bsr)         tdo_out <= bsr[0];
            else if (sel_id)          tdo_out <= id_sh[0];
            else                      tdo_out <= byp;
        end
    end

    AST_RESET_IR: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state == ST_RESET) |=> (ir == INS_IDCODE)) else $error("reset state did not load identification");
    AST_ID_CAPTURE: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (rise && state == ST_CAP_DR && sel_id) |=> (id_sh[ID_START] && id_sh == id_word))
        else $error("identification capture wrong");
    AST_ID_SHIFT: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (rise && state == ST_SH_DR && sel_id) |=> (id_sh[ID_LEN-2:0] == $past(id_sh[ID_LEN-1:1])))
        else $error("identification shift wrong");
    AST_BYP_SHIFT: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (rise && state == ST_SH_DR) |=> (byp == $past(pins_s2.tdi))) else $error("bypass did not take input");
    AST_BYP_CLEAR: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (rise && state == ST_CAP_DR) |=> !byp) else $error("bypass not cleared at capture");
    AST_BSR_IN: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (rise && state == ST_SH_DR && sel_bsr) |=> (bsr[BSR_LEN-1] == $past(pins_s2.tdi)))
        else $error("boundary chain did not take input");
    AST_BSR_ORDER: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (rise && state == ST_SH_DR && sel_bsr) |=> (bsr[BSR_LEN-2:0] == $past(bsr[BSR_LEN-1:1])))
        else $error("boundary chain order wrong");
    AST_QBUS: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (ir == INS_EXTEST) ##1 (ir == INS_EXTEST) |=> (q_drive_en_out == $past(oe_cell)))
        else $error("output enable does not follow internal cell");
    AST_TDO_FALL: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ($changed(tdo_out) || $changed(tdo_oe_out)) |-> $past(fall)) else $error("serial output moved off falling edge");
    AST_FSM_IDLE: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (rise && state == ST_RESET && !pins_s2.tms) |=> (state == ST_IDLE)) else $error("reset state exit wrong");
endmodule
